// >>> bench/wdg_window_dog_asserts.sv
// port checker of the window watchdog, bound to the top module
module wdg_wd_chk
	import wdg_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        sys_rst,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        irq,
	input wire logic        reset_req
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	logic        lk_q;
	logic [31:0] cr_q;
	logic [1:0]  mk_q;
	logic        en;

	// shadow of the single control write that may land, and of the mask
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			lk_q <= 1'b0;
			cr_q <= CTRL_RESET;
			mk_q <= MASK_RESET;
		end else if (reg_wr) begin
			if (reg_addr == OFS_CONTROL && !lk_q) begin
				lk_q <= 1'b1;
				cr_q <= reg_wdata & 32'h803f0f03;
			end
			if (reg_addr == OFS_IRQ_MASK) begin
				mk_q <= reg_wdata[1:0];
			end
		end
	end
	assign en = cr_q[CTRL_EN_BIT];

	// one read strobe cycle at a given offset
	sequence s_rd(logic [7:0] a);
		reg_rd && reg_addr == a;
	endsequence

	property p_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
	a_idle: assert property (p_idle)
		else $error("read data not zero outside a read");
	property p_cnt; s_rd(OFS_COUNT) |=> reg_rdata[31:6] == 26'h0; endproperty
	a_cnt: assert property (p_cnt)
		else $error("count register upper bits not zero");
	property p_lock; s_rd(OFS_CONTROL) |=> reg_rdata == cr_q; endproperty
	a_lock: assert property (p_lock)
		else $error("control value differs from first write");
	property p_hole; s_rd(8'h18) |=> reg_rdata == 32'h0; endproperty
	a_hole: assert property (p_hole)
		else $error("unmapped read not zero");
	property p_dis; !en |-> !reset_req; endproperty
	a_dis: assert property (p_dis)
		else $error("reset request while disabled");
	property p_stick; reset_req |=> reset_req; endproperty
	a_stick: assert property (p_stick)
		else $error("reset request dropped");
	property p_noirq; !en |-> !irq; endproperty
	a_noirq: assert property (p_noirq)
		else $error("interrupt while disabled");
	property p_rirq; $rose(reset_req) && mk_q[1] |-> ##[1:2] irq; endproperty
	a_rirq: assert property (p_rirq)
		else $error("no interrupt after watchdog reset");
endmodule : wdg_wd_chk

bind wdg_window_dog wdg_wd_chk u_chk (.core_clk(core_clk),
	.sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.irq(irq), .reset_req(reset_req));

// >>> bench/wdg_window_dog_tb.sv
// self-checking bench of the window watchdog
module wdg_window_dog_tb
	import wdg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        core_clk   = 1'b0;
	logic        sys_rst    = 1'b1;
	logic        clk_en     = 1'b1;
	logic [7:0]  reg_addr   = 8'h00;
	logic [31:0] reg_wdata  = 32'h0;
	logic        reg_wr     = 1'b0;
	logic        reg_rd     = 1'b0;
	logic        osc_10k    = 1'b0;
	logic        cpu_halted = 1'b0;
	logic [31:0] reg_rdata;
	logic        irq;
	logic        reset_req;
	int          err_count  = 0;
	int          n_tests    = 0;
	int          cyc        = 0;
	int          t0;
	logic [31:0] d;
	logic [31:0] e;
	logic [5:0]  win;
	// clock source reads 1: do_rst selects the oscillator after each reset
	logic [31:0] rv [6] = '{CTRL_RESET, 32'h0, 32'h3f, 32'h1, 32'h3, 32'h0};

	wdg_window_dog uut (.core_clk(core_clk), .sys_rst(sys_rst),
		.clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.osc_10k(osc_10k), .cpu_halted(cpu_halted), .irq(irq),
		.reset_req(reset_req));

	always #10 core_clk = ~core_clk;

	// fast oscillator stand-in (tick every 8 cycles) and hang guard
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc % 4 == 3) osc_10k <= ~osc_10k;
		if (cyc == 20000) begin
			err_count++;
			print_verdict();
		end
	end

	function automatic logic [31:0] ctl(input logic g, input logic [5:0] w,
		input logic [3:0] ps);
		ctl = {g, 9'h0, w, 4'h0, ps, 6'h0, 2'h3};
	endfunction : ctl

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	task automatic chk(input string nm, input logic [31:0] x,
		input logic [31:0] g);
		n_tests++;
		if (g !== x) begin
			$display("[FAIL] %s expected %h seen %h", nm, x, g);
			err_count++;
		end
	endtask : chk

	task automatic do_rst();
		@(posedge core_clk);
		sys_rst <= 1'b1;
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		wr(OFS_CLK_SRC, 32'h1);
	endtask : do_rst

	// bounded wait for the reset request
	task automatic wait_rst();
		for (int i = 0; i < 3000 && reset_req !== 1'b1; i++) @(posedge core_clk);
	endtask : wait_rst

	task automatic print_verdict();
		if (err_count == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : print_verdict

	initial begin
		void'($urandom(32'hc864));
		do_rst();
		// reset values, including an unmapped hole
		for (int i = 0; i < 6; i++) begin
			rd(8'(4 * i + 4));
			chk("reset value", rv[i], d);
		end
		// key while disabled is ignored, then an early key
		wr(OFS_RELOAD, RELOAD_KEY);
		win = 6'(8 + $urandom % 41);
		wr(OFS_CONTROL, ctl(1'b0, win, 4'h0));
		wr(OFS_CONTROL, 32'h0);
		rd(OFS_CONTROL);
		chk("control", ctl(1'b0, win, 4'h0), d);
		wr(OFS_RELOAD, RELOAD_KEY);
		#1 chk("early key", 32'h1, 32'(reset_req));
		rd(OFS_STATUS);
		chk("status", 32'h2, d);
		chk("irq", 32'h1, 32'(irq));
		wr(OFS_STATUS, 32'h2);
		rd(OFS_STATUS);
		chk("status", 32'h0, d);
		// match, clear, reload in window
		do_rst();
		wr(OFS_CONTROL, ctl(1'b0, win, 4'h0));
		wr(OFS_RELOAD, $urandom | 32'h10000);
		#1 chk("bad key", 32'h0, 32'(reset_req));
		for (int i = 0; i < 300; i++) begin
			rd(OFS_COUNT);
			if (d[5:0] <= win) break;
		end
		rd(OFS_STATUS);
		chk("status", 32'h1, d);
		chk("irq", 32'h1, 32'(irq));
		wr(OFS_STATUS, 32'h1);
		rd(OFS_STATUS);
		chk("status", 32'h0, d);
		wr(OFS_RELOAD, RELOAD_KEY);
		rd(OFS_COUNT);
		chk("pending", 32'h0, 32'(d[5:0] == CNT_TOP));
		repeat (40) @(posedge core_clk);
		rd(OFS_COUNT);
		chk("reloaded", 32'h1, 32'(d[5:0] >= 6'h3b));
		// halt freezes while the ignore bit is low
		@(posedge core_clk);
		cpu_halted <= 1'b1;
		rd(OFS_COUNT);
		e = d;
		repeat (80) @(posedge core_clk);
		rd(OFS_COUNT);
		chk("halted", e, d);
		@(posedge core_clk);
		cpu_halted <= 1'b0;
		wait_rst();
		rd(OFS_COUNT);
		chk("count", 32'h0, d);
		rd(OFS_STATUS);
		chk("status", 32'h3, d);
		// core/2048 source: first step about 2044 cycles after enable;
		// 1100 frozen cycles of clock enable push it past the next read
		do_rst();
		wr(OFS_CLK_SRC, 32'h0);
		wr(OFS_CONTROL, ctl(1'b0, 6'h10, 4'h0));
		repeat (1000) @(posedge core_clk);
		rd(OFS_COUNT);
		chk("core source early", 32'h3f, d);
		@(posedge core_clk);
		clk_en <= 1'b0;
		repeat (1100) @(posedge core_clk);
		clk_en <= 1'b1;
		rd(OFS_COUNT);
		chk("frozen", 32'h3f, d);
		repeat (1100) @(posedge core_clk);
		rd(OFS_COUNT);
		chk("core source step", 32'h3e, d);
		// factor 2, halt ignored: 63 steps of 2 ticks of 8 cycles,
		// first tick 1 to 8 cycles after enable, 2 cycles of latency
		do_rst();
		cpu_halted <= 1'b1;
		wr(OFS_CONTROL, ctl(1'b1, 6'h2, 4'h1));
		t0 = cyc;
		wait_rst();
		t0 = cyc - t0 - 63 * 2 * 8;
		chk("time-out", 32'h1, 32'(t0 > -6 && t0 < 3));
		print_verdict();
	end
endmodule : wdg_window_dog_tb

// >>> core/wdg_pkg.sv
// constants, register map and field layout of the window watchdog
package wdg_pkg;

	// register offsets (byte addresses)
	localparam logic [7:0]  OFS_RELOAD     = 8'h00;
	localparam logic [7:0]  OFS_CONTROL    = 8'h04;
	localparam logic [7:0]  OFS_STATUS     = 8'h08;
	localparam logic [7:0]  OFS_COUNT      = 8'h0c;
	localparam logic [7:0]  OFS_CLK_SRC    = 8'h10;
	localparam logic [7:0]  OFS_IRQ_MASK   = 8'h14;

	// control register layout
	localparam int          CTRL_EN_BIT    = 0;
	localparam int          CTRL_IE_BIT    = 1;
	localparam int          CTRL_PSEL_LSB  = 8;
	localparam int          CTRL_WIN_LSB   = 16;
	localparam int          CTRL_DBG_BIT   = 31;
	localparam logic [31:0] CTRL_RESET     = 32'h003f0800;

	// status / mask layout, count value layout
	localparam int          STAT_MATCH_BIT = 0;
	localparam int          STAT_RST_BIT   = 1;
	localparam int          CNT_LSB        = 0;
	localparam int          SRC_OSC_BIT    = 0;
	localparam logic [1:0]  MASK_RESET     = 2'h3;

	// counter, key and timing
	localparam int          CNT_W          = 6;
	localparam int          PSEL_W         = 4;
	localparam int          PRE_W          = 11;
	localparam logic [5:0]  CNT_TOP        = 6'h3f;
	localparam logic [5:0]  CNT_ZERO       = 6'h00;
	localparam logic [5:0]  CNT_STEP       = 6'h01;
	localparam logic [31:0] RELOAD_KEY     = 32'h00005aa5;
	localparam int          SYS_DIV        = 2048;
	localparam logic [10:0] SYS_DIV_LIMIT  = 11'(SYS_DIV - 1);
	localparam logic [1:0]  SYNC_LAST      = 2'h2;
	localparam logic [1:0]  SYNC_STEP      = 2'h1;

	// prescale factor minus one, for the terminal count of the prescaler
	function automatic logic [10:0] wdg_pre_limit(input logic [3:0] sel);
		case (sel)
			4'h0: wdg_pre_limit = 11'h000;
			4'h1: wdg_pre_limit = 11'h001;
			4'h2: wdg_pre_limit = 11'h003;
			4'h3: wdg_pre_limit = 11'h007;
			4'h4: wdg_pre_limit = 11'h00f;
			4'h5: wdg_pre_limit = 11'h01f;
			4'h6: wdg_pre_limit = 11'h03f;
			4'h7: wdg_pre_limit = 11'h07f;
			4'h8: wdg_pre_limit = 11'h0bf;
			4'h9: wdg_pre_limit = 11'h0ff;
			4'ha: wdg_pre_limit = 11'h17f;
			4'hb: wdg_pre_limit = 11'h1ff;
			4'hc: wdg_pre_limit = 11'h2ff;
			4'hd: wdg_pre_limit = 11'h3ff;
			4'he: wdg_pre_limit = 11'h5ff;
			default: wdg_pre_limit = 11'h7ff;
		endcase
	endfunction : wdg_pre_limit

endpackage : wdg_pkg

// >>> core/wdg_tick_gen.sv
// counting divider that pulses once every limit+1 steps
module wdg_tick_gen
	import wdg_pkg::*;
#(
	parameter int W = PRE_W
) (
	input  wire logic         core_clk,
	input  wire logic         sys_rst,
	input  wire logic         clk_en,
	input  wire logic         clear,
	input  wire logic         step,
	input  wire logic [W-1:0] limit,
	output logic              tick
);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         tick;
	} wdg_tick_state_t;

	wdg_tick_state_t s_q;
	wdg_tick_state_t s_d;

	// count steps, wrap at limit; clear restarts the period
	always_comb begin
		s_d      = s_q;
		s_d.tick = 1'b0;
		if (clear) begin
			s_d.cnt = '0;
		end else if (step) begin
			if (s_q.cnt >= limit) begin
				s_d.cnt  = '0;
				s_d.tick = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt + W'(1);
			end
		end
	end

	// frozen while the clock enable is low
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s_q <= '0;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;

endmodule : wdg_tick_gen

// >>> core/wdg_window_dog.sv
// window watchdog: 6-bit down counter, reload window, reset and irq
//
// Behaviour
// [R1] clock from core/2048 or 10 kHz oscillator
// [R2] prescale select decodes to sixteen factors
// [R3] longest time-out is factor times 64; counter here runs 63 steps to zero
// [R4] enable starts counter at 0x3f, counts down
// [R5] control register takes only one write
// [R6] enable bit low stops the counter
// [R7] status bit 0 sets on match, write-one clears
// [R8] match interrupt when flag and enable set
// [R9] key write reloads counter to 0x3f
// [R10] counter reaching zero requests system reset
// [R11] key above window requests reset at once
// [R12] reload lands three watchdog clocks after write
// [R13] software keeps window at least 3 or 2
// [R14] control bit 31 low freezes on debug halt
// [R15] status bit 1 flags watchdog reset, write-one clears
// [R16] window bits 21:16, prescale bits 11:8
// [R17] live counter in count register bits 5:0
// [R18] writes other than key are ignored
module wdg_window_dog
	import wdg_pkg::*;
#(
	parameter int AW = 8
) (
	input  wire logic          core_clk,
	input  wire logic          sys_rst,
	input  wire logic          clk_en,
	input  wire logic [AW-1:0] reg_addr,
	input  wire logic [31:0]   reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output logic      [31:0]   reg_rdata,
	input  wire logic          osc_10k,
	input  wire logic          cpu_halted,
	output logic               irq,
	output logic               reset_req
);

	typedef struct packed {
		logic              ctrl_locked;
		logic              counter_enable;
		logic              match_irq_enable;
		logic              debug_halt_ignore;
		logic [CNT_W-1:0]  window_compare;
		logic [PSEL_W-1:0] prescale_select;
		logic [CNT_W-1:0]  down_count_value;
		logic              match_flag;
		logic              reset_occurred_flag;
		logic [1:0]        irq_mask;
		logic              src_osc;
		logic              reload_pend;
		logic [1:0]        sync_cnt;
		logic              rst_req;
		logic              irq;
		logic [31:0]       rdata;
		logic [2:0]        osc_sync;
	} wdg_state_t;

	wdg_state_t s_q;
	wdg_state_t s_d;

	logic             div_tick;
	logic             pre_tick;
	logic             wd_tick;
	logic             osc_edge;
	logic             running;
	logic             pre_clear;
	logic [PRE_W-1:0] pre_limit;
	logic             wr_reload;
	logic             wr_ctrl;
	logic             wr_status;
	logic             key_ok;
	logic             reload_now;
	logic             cnt_dec;
	logic [CNT_W-1:0] cnt_next;

	// fixed divide-by-2048 of the core clock
	wdg_tick_gen #(
		.W (PRE_W)
	) u_sys_div (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.clear    (1'b0),
		.step     (1'b1),
		.limit    (SYS_DIV_LIMIT),
		.tick     (div_tick)
	);

	// oscillator edge seen only after the second sync stage
	assign osc_edge = s_q.osc_sync[1] & ~s_q.osc_sync[2];

	// one watchdog clock period per pulse, from either source
	assign wd_tick = s_q.src_osc ? osc_edge : div_tick; // [R1]

	// counting needs enable, no pending reset, and no debugger hold
	assign running = s_q.counter_enable & ~s_q.rst_req // [R6]
		& (s_q.debug_halt_ignore | ~cpu_halted); // [R14]

	// prescaler restarts on a reload so each period starts full
	assign pre_limit = wdg_pre_limit(s_q.prescale_select); // [R2]
	assign pre_clear = ~s_q.counter_enable | reload_now;

	// 63 counter steps of factor watchdog clocks each
	wdg_tick_gen #(
		.W (PRE_W)
	) u_prescale (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.clear    (pre_clear),
		.step     (wd_tick & running),
		.limit    (pre_limit),
		.tick     (pre_tick)
	); // [R3]

	// register write decode
	assign wr_reload = reg_wr & (reg_addr == AW'(OFS_RELOAD));
	assign wr_ctrl   = reg_wr & (reg_addr == AW'(OFS_CONTROL));
	assign wr_status = reg_wr & (reg_addr == AW'(OFS_STATUS));
	assign key_ok    = wr_reload & (reg_wdata == RELOAD_KEY); // [R18]

	// reload lands on the third watchdog clock after the key write
	assign reload_now = s_q.reload_pend & wd_tick & running
		& (s_q.sync_cnt == SYNC_LAST); // [R12]

	// one step down on each prescaled tick, never below zero
	assign cnt_dec  = pre_tick & running
		& (s_q.down_count_value != CNT_ZERO); // [R4]
	assign cnt_next = s_q.down_count_value - CNT_STEP;

	// next state of the whole block
	always_comb begin
		s_d       = s_q;
		s_d.rdata = '0;

		// two stages before any logic looks at the oscillator pin
		s_d.osc_sync = {s_q.osc_sync[1:0], osc_10k};

		// control accepts a single write; later writes are dropped
		if (wr_ctrl && !s_q.ctrl_locked) begin
			s_d.ctrl_locked       = 1'b1; // [R5]
			s_d.counter_enable    = reg_wdata[CTRL_EN_BIT];
			s_d.match_irq_enable  = reg_wdata[CTRL_IE_BIT];
			s_d.debug_halt_ignore = reg_wdata[CTRL_DBG_BIT];
			s_d.window_compare    =
				reg_wdata[CTRL_WIN_LSB +: CNT_W]; // [R16]
			s_d.prescale_select   =
				reg_wdata[CTRL_PSEL_LSB +: PSEL_W]; // [R16]
		end

		// clock source and irq mask are free to change
		if (reg_wr && reg_addr == AW'(OFS_CLK_SRC)) begin
			s_d.src_osc = reg_wdata[SRC_OSC_BIT];
		end
		if (reg_wr && reg_addr == AW'(OFS_IRQ_MASK)) begin
			s_d.irq_mask = reg_wdata[1:0];
		end

		// counter: reload has priority over the step down
		if (reload_now) begin
			s_d.down_count_value = CNT_TOP; // [R9]
			s_d.reload_pend      = 1'b0;
			s_d.sync_cnt         = '0;
		end else if (cnt_dec) begin
			s_d.down_count_value = cnt_next; // [R4]
		end

		// sync counter advances per watchdog clock while pending
		if (s_q.reload_pend && !reload_now && wd_tick && running) begin
			s_d.sync_cnt = s_q.sync_cnt + SYNC_STEP; // [R12]
		end

		// accepted key write: inside window starts the sync,
		// above the window trips the reset straight away
		if (key_ok && s_q.counter_enable && !s_q.rst_req) begin
			if (s_q.down_count_value > s_q.window_compare) begin
				s_d.rst_req = 1'b1; // [R11]
			end else if (!s_q.reload_pend) begin
				s_d.reload_pend = 1'b1; // [R9]
				s_d.sync_cnt    = '0;
			end
		end

		// running out before the reload lands is fatal
		if (cnt_dec && cnt_next == CNT_ZERO && !reload_now) begin
			s_d.rst_req = 1'b1; // [R10]
		end

		// match flag: write-one clear, a same-cycle match wins
		if (wr_status && reg_wdata[STAT_MATCH_BIT]) begin
			s_d.match_flag = 1'b0;
		end
		if (cnt_dec && cnt_next == s_q.window_compare) begin
			s_d.match_flag = 1'b1; // [R7]
		end

		// reset flag: raised with the request, write-one clears
		if (wr_status && reg_wdata[STAT_RST_BIT]) begin
			s_d.reset_occurred_flag = 1'b0;
		end
		if (s_d.rst_req && !s_q.rst_req) begin
			s_d.reset_occurred_flag = 1'b1; // [R15]
		end

		// level interrupt; match also needs its enable bit
		s_d.irq = (s_q.match_flag & s_q.match_irq_enable // [R8]
			& s_q.irq_mask[STAT_MATCH_BIT])
			| (s_q.reset_occurred_flag & s_q.irq_mask[STAT_RST_BIT]);

		// read data for the cycle after the strobe
		if (reg_rd) begin
			case (reg_addr)
				AW'(OFS_CONTROL): begin
					s_d.rdata[CTRL_EN_BIT]  = s_q.counter_enable;
					s_d.rdata[CTRL_IE_BIT]  = s_q.match_irq_enable;
					s_d.rdata[CTRL_DBG_BIT] = s_q.debug_halt_ignore;
					s_d.rdata[CTRL_WIN_LSB +: CNT_W] =
						s_q.window_compare;
					s_d.rdata[CTRL_PSEL_LSB +: PSEL_W] =
						s_q.prescale_select;
				end
				AW'(OFS_STATUS): begin
					s_d.rdata[STAT_MATCH_BIT] = s_q.match_flag;
					s_d.rdata[STAT_RST_BIT]   = s_q.reset_occurred_flag;
				end
				AW'(OFS_COUNT): begin
					s_d.rdata[CNT_LSB +: CNT_W] =
						s_q.down_count_value; // [R17]
				end
				AW'(OFS_CLK_SRC): begin
					s_d.rdata[SRC_OSC_BIT] = s_q.src_osc;
				end
				AW'(OFS_IRQ_MASK): begin
					s_d.rdata[1:0] = s_q.irq_mask;
				end
				// reload key is write-only; unmapped reads as zero
				default: begin
					s_d.rdata = '0;
				end
			endcase
		end
	end

	// single state register, frozen when the clock enable is low
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s_q                     <= '0;
			s_q.counter_enable      <= CTRL_RESET[CTRL_EN_BIT];
			s_q.match_irq_enable    <= CTRL_RESET[CTRL_IE_BIT];
			s_q.debug_halt_ignore   <= CTRL_RESET[CTRL_DBG_BIT];
			s_q.window_compare      <= CTRL_RESET[CTRL_WIN_LSB +: CNT_W];
			s_q.prescale_select     <= CTRL_RESET[CTRL_PSEL_LSB +: PSEL_W];
			s_q.down_count_value    <= CNT_TOP;
			s_q.irq_mask            <= MASK_RESET;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	// all outputs straight from the state register
	assign reg_rdata = s_q.rdata;
	assign irq       = s_q.irq;
	assign reset_req = s_q.rst_req;

endmodule : wdg_window_dog
